/* include/lepc_pkg.sv */
// Summary of operation
// - Bit 15 of the energy control register enables energy sensing, resets to 0.
// - With auto_wake (bit 14, reset 1) set, power-up starts once data events reach the threshold.
// - With auto_sleep (bit 13, reset 1) set, power-down starts once no line energy is sensed.
// - Writing 1 to bit 12 starts a power change and the bit clears itself.
// - The manual toggle changes power state at once, ignoring thresholds and timers.
// - Each line-driver power-up sends 4 energy pulses, or one when pulse_burst_off is set.
// - The activity threshold is a writable field in bits 3:0, reset 0001.
// - Bit 8 is set when data events meet the activity threshold and clears on read.
// - Event counters reset after about 2 seconds without a data event.
package lepc_pkg;
	// Register indices; the byte address on APB is four times the index.
	localparam logic [7:0] IDX_CONTROL   = 8'h1D;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h1E;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h1F;
	// Control register field positions.
	localparam int B_ENABLE    = 15;
	localparam int B_WAKE      = 14;
	localparam int B_SLEEP     = 13;
	localparam int B_MANUAL    = 12;
	localparam int B_BURST_OFF = 11;
	localparam int B_PWR_STATE = 10;
	localparam int B_ERR_MET   = 9;
	localparam int B_DATA_MET  = 8;
	localparam int B_NOISE_LO  = 4;
	localparam int B_ACT_LO    = 0;
	localparam int THR_W       = 4;
	// Reset values.
	localparam logic [THR_W-1:0] THR_RESET   = 4'h1;
	localparam logic             WAKE_RESET  = 1'h1;
	localparam logic             SLEEP_RESET = 1'h1;
	// Interrupt status bit positions.
	localparam int IRQ_W       = 3;
	localparam int I_WOKE      = 0;
	localparam int I_SLEPT     = 1;
	localparam int I_DATA_MET  = 2;
	// Timing.
	localparam int CLK_HZ        = 50_000_000;
	localparam int IDLE_TIME_MS  = 2000;
	localparam int IDLE_CYCLES   = IDLE_TIME_MS * (CLK_HZ / 1000);
	localparam int BURST_LEN     = 4;
	localparam int PULSE_GAP_NS  = 100;
	localparam int PULSE_GAP_CYC = (PULSE_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	typedef enum logic {LEPC_ASLEEP, LEPC_AWAKE} lepc_pwr_e;
endpackage

/* include/lepc_if.sv */
`timescale 1ns/100ps
// Handshake between the power controller and the pulse generator.
interface lepc_if;
	logic start;
	logic burst_off;
	logic pulse;
	modport ctl (output start, output burst_off, input pulse);
	modport gen (input start, input burst_off, output pulse);
endinterface

/* design/lepc_pulse.sv */
`timescale 1ns/100ps
// Sends a burst of one-cycle energy pulses each time the line driver powers up.
module lepc_pulse #(
	parameter int BURST = lepc_pkg::BURST_LEN,
	parameter int GAP   = lepc_pkg::PULSE_GAP_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	lepc_if.gen       pif
);
	logic [3:0]  left;
	logic [15:0] gap_cnt;
	wire         gap_done = (gap_cnt == 16'h0);

	// A new start restarts the burst, so a fast sleep and wake never loses its pulses.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left    <= 4'h0;
			gap_cnt <= 16'h0;
			pif.pulse <= 1'b0;
		end else if (pif.start) begin
			left    <= pif.burst_off ? 4'h1 : 4'(BURST);
			gap_cnt <= 16'h0;
			pif.pulse <= 1'b0;
		end else if (left != 4'h0 && gap_done && !pif.pulse) begin
			left    <= left - 4'h1;
			gap_cnt <= 16'(GAP);
			pif.pulse <= 1'b1;
		end else begin
			pif.pulse <= 1'b0;
			if (!gap_done) begin
				gap_cnt <= gap_cnt - 16'h1;
			end
		end
	end
endmodule

/* design/lepc_top.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
// Energy-sense power control with an APB register port.
module lepc_top #(
	parameter int IDLE_CYCLES = lepc_pkg::IDLE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        data_event,
	input  wire logic        error_event,
	input  wire logic        line_energy,
	output logic             driver_power_on,
	output logic             pulse_out,
	output logic             irq
);
	lepc_if pif ();

	// Control fields.
	logic                            energy_sense_enable;
	logic                            auto_wake;
	logic                            auto_sleep;
	logic                            manual_power_toggle;
	logic                            pulse_burst_off;
	logic                            activity_threshold_reached;
	logic                            noise_threshold_reached;
	logic [lepc_pkg::THR_W-1:0]      activity_threshold;
	logic [lepc_pkg::THR_W-1:0]      noise_threshold;
	logic [lepc_pkg::IRQ_W-1:0]      irq_status;
	logic [lepc_pkg::IRQ_W-1:0]      irq_mask;
	lepc_pkg::lepc_pwr_e             pwr;
	logic [lepc_pkg::THR_W-1:0]      data_cnt;
	logic [lepc_pkg::THR_W-1:0]      err_cnt;
	logic [31:0]                     idle_cnt;
	logic                            start_q;

	// Bus decode: a request is answered one cycle into its access phase.
	// Every transfer thus costs one wait state; answering in the first access cycle
	// would put the address decode and read mux straight in front of pready.
	// Only word addresses are compared, so the two low address bits are ignored.
	wire        access     = psel & penable & ~pready;
	wire        done       = psel & penable & pready;
	wire [29:0] word       = paddr[31:2];
	wire        hit_ctl    = (word == 30'(lepc_pkg::IDX_CONTROL));
	wire        hit_stat   = (word == 30'(lepc_pkg::IDX_IRQ_STAT));
	wire        hit_mask   = (word == 30'(lepc_pkg::IDX_IRQ_MASK));
	wire        mapped     = hit_ctl | hit_stat | hit_mask;
	wire        wr_ctl     = done & pwrite & hit_ctl;
	wire        wr_stat    = done & pwrite & hit_stat;
	wire        wr_mask    = done & pwrite & hit_mask;
	wire        rd_ctl     = done & ~pwrite & hit_ctl;

	// Control register image as software reads it.
	// The power state bit is only meaningful while sensing is enabled; with sensing
	// off the block is held awake and the bit simply reads as one.
	wire [15:0] ctl_image  = {energy_sense_enable, auto_wake, auto_sleep, manual_power_toggle,
		pulse_burst_off, (pwr == lepc_pkg::LEPC_AWAKE), noise_threshold_reached,
		activity_threshold_reached, noise_threshold, activity_threshold};
	wire [31:0] rd_data    = hit_ctl  ? {16'h0000, ctl_image} :
	                         hit_stat ? {29'h0, irq_status} :
	                         hit_mask ? {29'h0, irq_mask} : 32'h0000_0000;

	// Event counting: the next counts saturate rather than wrap.
	// Saturation matters: a wrapped count would fall below the threshold again and
	// hide a run of events that arrived while the state could not change.
	wire [lepc_pkg::THR_W-1:0] next_data_cnt = (&data_cnt) ? data_cnt : data_cnt + 4'h1;
	wire [lepc_pkg::THR_W-1:0] next_err_cnt  = (&err_cnt) ? err_cnt : err_cnt + 4'h1;
	wire data_hit   = data_event & (next_data_cnt >= activity_threshold);
	wire err_hit    = error_event & (next_err_cnt >= noise_threshold);
	wire idle_done  = (idle_cnt >= 32'(IDLE_CYCLES - 1));

	// Power transitions; the manual toggle overrides every automatic cause.
	// Both automatic causes are gated by the current state, so a wake cause while
	// already awake, or a sleep cause while asleep, leaves the state alone.
	// With sensing disabled none of these fire and force_up pulls the state back up.
	wire man_go     = energy_sense_enable & manual_power_toggle;
	wire wake_go    = energy_sense_enable & auto_wake & data_hit
	                  & (pwr == lepc_pkg::LEPC_ASLEEP);
	wire sleep_go   = energy_sense_enable & auto_sleep & ~line_energy
	                  & (pwr == lepc_pkg::LEPC_AWAKE);
	wire go_up      = man_go ? (pwr == lepc_pkg::LEPC_ASLEEP) : wake_go;
	wire go_down    = man_go ? (pwr == lepc_pkg::LEPC_AWAKE) : sleep_go;
	wire force_up   = ~energy_sense_enable & (pwr == lepc_pkg::LEPC_ASLEEP);
	wire [lepc_pkg::IRQ_W-1:0] irq_set = {data_hit, go_down, go_up | force_up};

	// APB answer, registered so every bus output comes from a flop.
	// Read data is zero outside the answer cycle, so a stale word never shows on the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// Writable control fields.
	// A new threshold applies from the next event; counts already gathered are kept.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_sense_enable <= 1'b0;
			auto_wake           <= lepc_pkg::WAKE_RESET;
			auto_sleep          <= lepc_pkg::SLEEP_RESET;
			pulse_burst_off     <= 1'b0;
			noise_threshold     <= lepc_pkg::THR_RESET;
			activity_threshold  <= lepc_pkg::THR_RESET;
			irq_mask            <= '0;
		end else begin
			if (wr_ctl) begin
				energy_sense_enable <= pwdata[lepc_pkg::B_ENABLE];
				auto_wake           <= pwdata[lepc_pkg::B_WAKE];
				auto_sleep          <= pwdata[lepc_pkg::B_SLEEP];
				pulse_burst_off     <= pwdata[lepc_pkg::B_BURST_OFF];
				noise_threshold     <= pwdata[lepc_pkg::B_NOISE_LO +: lepc_pkg::THR_W];
				activity_threshold  <= pwdata[lepc_pkg::B_ACT_LO +: lepc_pkg::THR_W];
			end
			if (wr_mask) begin
				irq_mask <= pwdata[lepc_pkg::IRQ_W-1:0];
			end
		end
	end

	// The manual toggle is held for one cycle only, so it always reads back as zero.
	// A toggle written while sensing is off is dropped, since the block is then held awake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			manual_power_toggle <= 1'b0;
		end else begin
			manual_power_toggle <= wr_ctl & pwdata[lepc_pkg::B_MANUAL];
		end
	end

	// Power state; leaving sensing disabled always returns the block to awake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr <= lepc_pkg::LEPC_AWAKE;
		end else if (go_up | force_up) begin
			pwr <= lepc_pkg::LEPC_AWAKE;
		end else if (go_down) begin
			pwr <= lepc_pkg::LEPC_ASLEEP;
		end
	end

	// Event counters, cleared by a power change or by a long quiet spell.
	// The quiet timer restarts on every data event and on every power change, so the
	// two-second window measures silence since the last of them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_cnt <= '0;
			err_cnt  <= '0;
			idle_cnt <= 32'h0;
		end else if (go_up | go_down | force_up | (idle_done & ~data_event)) begin
			data_cnt <= '0;
			err_cnt  <= '0;
			idle_cnt <= 32'h0;
		end else begin
			if (data_event) begin
				data_cnt <= next_data_cnt;
			end
			if (error_event) begin
				err_cnt <= next_err_cnt;
			end
			idle_cnt <= data_event ? 32'h0 : idle_cnt + 32'h1;
		end
	end

	// Threshold flags clear on a control read, but a hit in that same cycle wins.
	// The error flag is informational only and never moves the power state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			activity_threshold_reached <= 1'b0;
			noise_threshold_reached    <= 1'b0;
		end else begin
			activity_threshold_reached <= data_hit | (activity_threshold_reached & ~rd_ctl);
			noise_threshold_reached    <= err_hit | (noise_threshold_reached & ~rd_ctl);
		end
	end

	// Sticky interrupt status, write one to clear, a new event beats the clear.
	// Masking gates only the output, so masked events can still be polled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= irq_set | (irq_status & ~({lepc_pkg::IRQ_W{wr_stat}}
				& pwdata[lepc_pkg::IRQ_W-1:0]));
			irq        <= |(irq_status & irq_mask);
		end
	end

	// Driver power follows the power state by one flop; the burst start is registered alongside the state change.
	// Pulses are gated with the power state, so a burst cut short by a power-down
	// never reaches an unpowered driver; such a burst is lost, not resumed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			driver_power_on <= 1'b1;
			start_q         <= 1'b0;
			pulse_out       <= 1'b0;
		end else begin
			driver_power_on <= (pwr == lepc_pkg::LEPC_AWAKE);
			start_q         <= go_up | force_up;
			pulse_out       <= pif.pulse & (pwr == lepc_pkg::LEPC_AWAKE);
		end
	end

	// Strobe and burst setting handed to the pulse generator.
	assign pif.start     = start_q;
	assign pif.burst_off = pulse_burst_off;

	// The generator restarts its burst on every start strobe, so a quick sleep and
	// wake still sends a full burst rather than the tail of the old one.
	lepc_pulse u_pulse (
		.pclk    (pclk),
		.presetn (presetn),
		.pif     (pif)
	);
endmodule

/* tb/lepc_assertions.sv */
`timescale 1ns/100ps
// Watches the register port and the line-side outputs of the energy power block.
module lepc_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        data_event,
	input wire logic        line_energy,
	input wire logic        driver_power_on,
	input wire logic        pulse_out
);
	logic [3:0] quiet;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since the last cause that may move the power state; it saturates to stay small.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) quiet <= 4'h0;
		else if (data_event || !line_energy || (pready && pwrite)) quiet <= 4'h0;
		else if (quiet != 4'hF) quiet <= quiet + 4'h1;
	end
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready outside an access phase");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero while idle");
	AST_PULSE_ONE: assert property (pulse_out |=> !pulse_out)
		else $error("energy pulse wider than one cycle");
	AST_PULSE_GAP: assert property (pulse_out |=> !pulse_out [*5])
		else $error("energy pulses too close");
	AST_PULSE_POWERED: assert property (pulse_out |-> driver_power_on)
		else $error("energy pulse while driver is off");
	AST_BURST_START: assert property ($rose(driver_power_on) |-> ##[1:4] pulse_out)
		else $error("no pulse after driver power-up");
	AST_NO_SPONTANEOUS: assert property ($changed(driver_power_on) |-> quiet < 4'h8)
		else $error("power state moved without a cause");
endmodule
bind lepc_top lepc_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .data_event, .line_energy, .driver_power_on, .pulse_out);

/* tb/lepc_link_partner.sv */
`timescale 1ns/100ps
// Cable partner: puts energy on the line and produces energy events.
module lepc_link_partner (
	input  wire logic pclk,
	output logic      data_event,
	output logic      error_event,
	output logic      line_energy
);
	// Quiet line at time zero, energy present.
	initial begin
		data_event = 1'h0;
		error_event = 1'h0;
		line_energy = 1'h1;
	end
	// Events are one-cycle pulses with an idle cycle between, so each one is counted once.
	task automatic burst(input int n, input logic e);
		repeat (n) begin
			@(posedge pclk);
			if (e) error_event <= 1'h1;
			else data_event <= 1'h1;
			@(posedge pclk);
			error_event <= 1'h0;
			data_event <= 1'h0;
		end
	endtask
	task automatic set_energy(input logic on);
		@(posedge pclk);
		line_energy <= on;
	endtask
endmodule

/* tb/line_energy_power_control_tb.sv */
`timescale 1ns/100ps
// Register-level tests of the energy power block against a cable partner.
module line_energy_power_control_tb;
	localparam int         IDLE = 200;
	localparam logic [7:0] CTL  = lepc_pkg::IDX_CONTROL;
	localparam logic [7:0] STA  = lepc_pkg::IDX_IRQ_STAT;
	localparam logic [7:0] MSK  = lepc_pkg::IDX_IRQ_MASK;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        data_event;
	logic        error_event;
	logic        line_energy;
	logic        driver_power_on;
	logic        pulse_out;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          miscompares;
	int          cmp_count;
	int          pulses;
	lepc_top #(.IDLE_CYCLES(IDLE)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .data_event, .error_event, .line_energy,
		.driver_power_on, .pulse_out, .irq);
	lepc_link_partner lp (.pclk, .data_event, .error_event, .line_energy);
	// Clock and a count of energy pulses seen on the line.
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) if (pulse_out === 1'h1) pulses++;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// The wait is bounded so that a slave that never answers shows as a mismatch.
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		check({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, idx, 32'h0);
		check(rd & m, e);
	endtask
	task automatic wait_pwr(input logic v);
		int n;
		n = 0;
		while (driver_power_on !== v && n < 12) begin
			@(posedge pclk);
			n++;
		end
		check({31'h0, driver_power_on}, {31'h0, v});
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the roughly five hundred cycles the tests need.
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		rd_chk(CTL, 32'hFFFF_FBFF, 32'h0000_6011);
		check({31'h0, driver_power_on}, 32'h1);
		rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test reset finished");
		lp.set_energy(1'h0);
		lp.burst(3, 1'h0);
		lp.burst(1, 1'h1);
		repeat (20) @(posedge pclk);
		check({31'h0, driver_power_on}, 32'h1);
		rd_chk(CTL, 32'h300, 32'h300);
		apb(1'h1, MSK, 32'h7);
		apb(1'h1, STA, 32'h7);
		apb(1'h1, CTL, 32'hE003);
		wait_pwr(1'h0);
		rd_chk(STA, 32'h2, 32'h2);
		check({31'h0, irq}, 32'h1);
		apb(1'h1, STA, 32'h2);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		$display("test sleep finished");
		lp.set_energy(1'h1);
		lp.burst(2, 1'h0);
		repeat (10) @(posedge pclk);
		check({31'h0, driver_power_on}, 32'h0);
		rd_chk(CTL, 32'h100, 32'h0);
		pulses = 0;
		lp.burst(1, 1'h0);
		wait_pwr(1'h1);
		repeat (40) @(posedge pclk);
		check(pulses, 32'h4);
		rd_chk(CTL, 32'h500, 32'h500);
		rd_chk(CTL, 32'h100, 32'h0);
		$display("test wake finished");
		apb(1'h1, STA, 32'h7);
		apb(1'h1, CTL, 32'h980F);
		wait_pwr(1'h0);
		rd_chk(CTL, 32'h1400, 32'h0);
		pulses = 0;
		apb(1'h1, CTL, 32'h980F);
		wait_pwr(1'h1);
		repeat (20) @(posedge pclk);
		check(pulses, 32'h1);
		$display("test manual finished");
		apb(1'h1, CTL, 32'h9000);
		wait_pwr(1'h0);
		apb(1'h1, CTL, 32'hC002);
		lp.burst(1, 1'h0);
		repeat (IDLE + 50) @(posedge pclk);
		lp.burst(1, 1'h0);
		repeat (10) @(posedge pclk);
		check({31'h0, driver_power_on}, 32'h0);
		lp.burst(1, 1'h0);
		wait_pwr(1'h1);
		$display("test idle finished");
		finish_test();
	end
endmodule
